// File: hdl/pcir_ctrl.v
// Card ready/busy-interrupt, reset and status-change controller
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "pcir_consts.vh"
module pcir_ctrl #(
    parameter PULSE_CYCLES = `PCIR_PULSE_CYC,
    parameter CNT_W = 8
) (
    input wire clk_in,
    input wire rst_n_in,
    // Card reset pin, active high, sampled on clk
    input wire card_iface_reset_in,
    // Internal interrupt line from the UART emulator
    input wire emulator_int_line_in,
    // Host strobes (active low)
    input wire host_write_strobe_n_in,
    input wire host_card_enable_n_in,
    input wire host_attr_select_n_in,
    // Host configuration write (decoded elsewhere) of option register
    input wire host_cfg_wr_in,
    input wire [7:0] host_cfg_data_in,
    // Host indication that interrupt was serviced (level mode)
    input wire host_int_ack_in,
    // Firmware register port
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // Pins
    output reg card_ready_busy_irq_n_out,
    output reg card_status_change_out,
    // Qualified attribute/config write toward memory
    output reg attr_write_ok_out,
    output reg fw_irq_out
);
    // Control bits owned by firmware
    reg ready_r;
    reg stschg_r;
    // Card configuration (option) register, written by host
    reg [7:0] option_r;
    // Card configured for I/O-and-memory operation
    reg io_cfg_r;
    // Level interrupt latch
    reg level_req_r;
    // Previous emulator line for edge detect
    reg emu_d_r;
    // Previous host write strobe condition
    reg hwr_d_r;
    // Interrupt mask
    reg [2:0] mask_r;

    wire emu_rise;
    wire pulse_mode;
    wire host_wr_now;
    wire host_wr_allowed;
    wire pulse_active;
    wire [2:0] ev_status;
    wire ev_pending;
    wire [2:0] events;
    wire fw_wr_ctrl;
    wire fw_clr_stat;
    wire fw_ack;
    wire irq_active;

    assign emu_rise = emulator_int_line_in & ~emu_d_r;
    assign pulse_mode = option_r[`PCIR_OPT_PULSE_BIT];
    assign host_wr_now = ~host_write_strobe_n_in & ~host_card_enable_n_in
        & ~host_attr_select_n_in;
    // memory-only needs pin high
    // The pin itself gates, not ready_r, which runs one cycle ahead of it
    assign host_wr_allowed = io_cfg_r | card_ready_busy_irq_n_out;
    assign fw_wr_ctrl = reg_wr_in && (reg_addr_in == `PCIR_ADDR_CTRL);
    assign fw_clr_stat = reg_wr_in && (reg_addr_in == `PCIR_ADDR_IRQ_STAT);
    assign fw_ack = fw_wr_ctrl && reg_wdata_in[`PCIR_CTRL_ACK_BIT];

    // Pulse stretcher: starts on a new emulator request when configured for pulsed mode and no pulse is running
    pcir_pulse_timer #(
        .CYCLES(PULSE_CYCLES),
        .WIDTH(CNT_W)
    ) u_pulse (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(card_iface_reset_in),
        .start_in(emu_rise & io_cfg_r & pulse_mode & ~card_iface_reset_in),
        .active_out(pulse_active)
    );

    assign events = {host_wr_now & ~hwr_d_r & ~host_wr_allowed,
        host_wr_now & ~hwr_d_r & host_wr_allowed,
        card_iface_reset_in};

    // Events for firmware
    pcir_event_regs #(
        .N(3)
    ) u_events (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .event_in(events),
        .clear_we_in(fw_clr_stat),
        .clear_in(reg_wdata_in[2:0]),
        .mask_in(mask_r),
        .status_out(ev_status),
        .pending_out(ev_pending)
    );

    // Firmware-owned control bits
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_r <= 1'b0;
            stschg_r <= 1'b0;
            mask_r <= 3'h0;
        end else begin
            if (card_iface_reset_in) begin
                ready_r <= 1'b0;
            end else if (fw_wr_ctrl) begin
                // Firmware sets ready once set-up is done
                ready_r <= reg_wdata_in[`PCIR_CTRL_READY_BIT];
            end
            if (fw_wr_ctrl) begin
                stschg_r <= reg_wdata_in[`PCIR_CTRL_STSCHG_BIT];
            end
            if (reg_wr_in && (reg_addr_in == `PCIR_ADDR_IRQ_MASK)) begin
                mask_r <= reg_wdata_in[2:0];
            end
        end
    end

    // Host-owned configuration, cleared by card reset
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            option_r <= `PCIR_OPTION_RST;
            io_cfg_r <= 1'b0;
        end else if (card_iface_reset_in) begin
            option_r <= `PCIR_OPTION_RST;
            io_cfg_r <= 1'b0;
        end else if (host_cfg_wr_in && host_wr_allowed) begin
            // Any nonzero configuration index enables I/O and memory
            option_r <= host_cfg_data_in;
            io_cfg_r <= (host_cfg_data_in[5:0] != 6'h00);
        end
    end

    // Level request: set by emulator, released after host service
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_req_r <= 1'b0;
        end else if (card_iface_reset_in || !io_cfg_r || pulse_mode) begin
            level_req_r <= 1'b0;
        end else if (emulator_int_line_in) begin
            level_req_r <= 1'b1;
        end else if (host_int_ack_in || fw_ack) begin
            level_req_r <= 1'b0;
        end
    end

    assign irq_active = pulse_mode ? pulse_active : level_req_r;

    // Pin and delay flops
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            card_ready_busy_irq_n_out <= 1'b0;
            card_status_change_out <= 1'b0;
            attr_write_ok_out <= 1'b0;
            fw_irq_out <= 1'b0;
            emu_d_r <= 1'b0;
            hwr_d_r <= 1'b0;
        end else begin
            emu_d_r <= emulator_int_line_in;
            hwr_d_r <= host_wr_now;
            if (!io_cfg_r) begin
                card_ready_busy_irq_n_out <= ready_r & ~card_iface_reset_in;
            end else begin
                card_ready_busy_irq_n_out <= ~irq_active;
            end
            card_status_change_out <= stschg_r;
            attr_write_ok_out <= host_wr_now & host_wr_allowed;
            fw_irq_out <= ev_pending;
        end
    end

    // Register read data, one cycle after strobe
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `PCIR_ADDR_CTRL: reg_rdata_out <= {5'h00, io_cfg_r, stschg_r, ready_r};
                `PCIR_ADDR_OPTION: reg_rdata_out <= option_r;
                `PCIR_ADDR_STATUS: reg_rdata_out <= {5'h00, pulse_active, level_req_r,
                    card_ready_busy_irq_n_out};
                `PCIR_ADDR_IRQ_STAT: reg_rdata_out <= {5'h00, ev_status};
                `PCIR_ADDR_IRQ_MASK: reg_rdata_out <= {5'h00, mask_r};
                default: reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end
endmodule // pcir_ctrl

// File: hdl/pcir_consts.vh
// Constants for the card ready/busy, interrupt and status-change block
// Overview of operation
// - After reset: memory-only, busy until firmware ready
// - Configured card: emulator interrupt drives request low
// - Pulsed mode: low pulse at least one microsecond
// - Level mode: hold request until host processed
// - Option register bit 6 selects pulse/level
// - Card reset clears configuration, memory-only mode
// - Status-change pin follows a control register bit
// - Memory-only writes accepted only while ready
`ifndef PCIR_CONSTS_VH
`define PCIR_CONSTS_VH
// Register addresses (local firmware port)
`define PCIR_ADDR_CTRL 4'h0
`define PCIR_ADDR_OPTION 4'h1
`define PCIR_ADDR_STATUS 4'h2
`define PCIR_ADDR_IRQ_STAT 4'h3
`define PCIR_ADDR_IRQ_MASK 4'h4
// Control register fields
`define PCIR_CTRL_READY_BIT 0
`define PCIR_CTRL_STSCHG_BIT 1
`define PCIR_CTRL_IO_CFG_BIT 2
`define PCIR_CTRL_ACK_BIT 3
// Option register field: pulsed (1) or level (0)
`define PCIR_OPT_PULSE_BIT 6
// Interrupt status bits
`define PCIR_EV_CARD_RESET 0
`define PCIR_EV_HOST_WRITE 1
`define PCIR_EV_WR_REFUSED 2
// Reset values
`define PCIR_CTRL_RST 8'h00
`define PCIR_OPTION_RST 8'h00
`define PCIR_MASK_RST 8'h00
// Timing: least pulse width
`define PCIR_PULSE_NS 1000
`define PCIR_CLK_NS 100
`define PCIR_PULSE_CYC ((`PCIR_PULSE_NS + `PCIR_CLK_NS - 1) / `PCIR_CLK_NS)
`endif

// File: hdl/pcir_pulse_timer.v
// Low-pulse stretcher for the pulsed host interrupt
`timescale 1ns/10ps
module pcir_pulse_timer #(
    parameter CYCLES = 10,
    parameter WIDTH = 8
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire clear_in,
    input wire start_in,
    output wire active_out
);
    // Remaining cycles of the current pulse
    reg [WIDTH-1:0] count_r;
    reg [WIDTH-1:0] count_nxt;

    // Load on start, count down to zero; clear aborts
    always @* begin
        count_nxt = count_r;
        if (clear_in) begin
            count_nxt = {WIDTH{1'b0}};
        end else if (start_in && (count_r == {WIDTH{1'b0}})) begin
            count_nxt = CYCLES[WIDTH-1:0];
        end else if (count_r != {WIDTH{1'b0}}) begin
            count_nxt = count_r - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Counter flop
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= {WIDTH{1'b0}};
        end else begin
            count_r <= count_nxt;
        end
    end

    assign active_out = (count_r != {WIDTH{1'b0}});
endmodule // pcir_pulse_timer

// File: hdl/pcir_event_regs.v
// Sticky event status with write-one-to-clear and mask
`timescale 1ns/10ps
module pcir_event_regs #(
    parameter N = 3
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire [N-1:0] event_in,
    input wire clear_we_in,
    input wire [N-1:0] clear_in,
    input wire [N-1:0] mask_in,
    output wire [N-1:0] status_out,
    output wire pending_out
);
    // Sticky flags
    reg [N-1:0] stat_r;
    genvar i;

    // Set wins over clear so no event is lost
    generate
        for (i = 0; i < N; i = i + 1) begin : g_bit
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    stat_r[i] <= 1'b0;
                end else if (event_in[i]) begin
                    stat_r[i] <= 1'b1;
                end else if (clear_we_in && clear_in[i]) begin
                    stat_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign status_out = stat_r;
    assign pending_out = |(stat_r & mask_in);
endmodule // pcir_event_regs

// File: tb/pcir_ctrl_assertions.sv
// Checker for the card pins and the firmware read port
`timescale 1ns/10ps
module pcir_chk #(
    parameter PULSE_CYCLES = 10
) (
    input wire clk_in,
    input wire rst_n_in,
    input wire card_iface_reset_in,
    input wire emulator_int_line_in,
    input wire host_write_strobe_n_in,
    input wire host_card_enable_n_in,
    input wire host_attr_select_n_in,
    input wire host_cfg_wr_in,
    input wire [7:0] host_cfg_data_in,
    input wire host_int_ack_in,
    input wire [3:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire card_ready_busy_irq_n_out,
    input wire card_status_change_out,
    input wire attr_write_ok_out
);
    reg pulse_mode_r; // Host chose pulsed signalling
    reg cfg_seen_r; // Host configured the card
    reg [15:0] low_cnt_r; // Cycles the pin has stayed low
    wire strobes_low = !host_write_strobe_n_in && !host_card_enable_n_in && !host_attr_select_n_in;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    // Shadow of host configuration; writes refused while busy leave it alone
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_mode_r <= 1'b0;
            cfg_seen_r <= 1'b0;
            low_cnt_r <= 16'h0000;
        end else begin
            low_cnt_r <= card_ready_busy_irq_n_out ? 16'h0000 : low_cnt_r + 16'h0001;
            if (card_iface_reset_in) begin
                pulse_mode_r <= 1'b0;
                cfg_seen_r <= 1'b0;
            end else if (host_cfg_wr_in && (cfg_seen_r || card_ready_busy_irq_n_out)) begin
                pulse_mode_r <= host_cfg_data_in[6];
                cfg_seen_r <= |host_cfg_data_in[5:0];
            end
        end
    end
    busy_on_reset_a: assert property (
        card_iface_reset_in |-> ##2 !card_ready_busy_irq_n_out) else $error("pin not busy");
    ready_release_a: assert property (
        reg_wr_in && reg_addr_in == 4'h0 && reg_wdata_in[0] && !cfg_seen_r
        && !card_iface_reset_in ##1 !card_iface_reset_in |-> ##1 card_ready_busy_irq_n_out)
        else $error("ready not shown");
    status_pin_a: assert property (
        reg_wr_in && reg_addr_in == 4'h0 |-> ##2
        card_status_change_out == $past(reg_wdata_in[1], 2)) else $error("status pin wrong");
    write_gate_a: assert property (
        attr_write_ok_out |-> $past(strobes_low) && ($past(card_ready_busy_irq_n_out)
        || $past(cfg_seen_r))) else $error("write passed while busy");
    rdata_idle_a: assert property (
        !$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("read data not idle");
    pulse_width_a: assert property (
        $rose(card_ready_busy_irq_n_out) && pulse_mode_r |-> low_cnt_r >= PULSE_CYCLES)
        else $error("pulse too short");
    level_hold_a: assert property (
        $rose(card_ready_busy_irq_n_out) && cfg_seen_r && !pulse_mode_r |->
        $past(host_int_ack_in) || $past(host_int_ack_in, 2) || $past(host_int_ack_in, 3))
        else $error("level request dropped early");
    emu_request_a: assert property (
        cfg_seen_r && $rose(emulator_int_line_in) |-> ##[1:3] !card_ready_busy_irq_n_out)
        else $error("no host request");
endmodule // pcir_chk

// File: tb/pcir_host_model.sv
// Host card-adapter model: strobes, option writes, interrupt service
`timescale 1ns/10ps
module pcir_host_model (
    input wire clk_in,
    input wire attr_ok_in,
    output logic we_n_out,
    output logic ce_n_out,
    output logic reg_n_out,
    output logic cfg_wr_out,
    output logic [7:0] cfg_data_out,
    output logic ack_out
);
    // Idle bus with all strobes released
    initial begin
        {we_n_out, ce_n_out, reg_n_out} = 3'h7;
        cfg_wr_out = 1'b0;
        cfg_data_out = 8'h00;
        ack_out = 1'b0;
    end
    // Attribute write; cfg also posts the option register
    task automatic host_write(input logic [7:0] d, input logic cfg, output logic seen);
        @(posedge clk_in);
        {we_n_out, ce_n_out, reg_n_out} <= 3'h0;
        cfg_wr_out <= cfg;
        cfg_data_out <= d;
        @(posedge clk_in);
        cfg_wr_out <= 1'b0;
        #1 seen = attr_ok_in;
        @(posedge clk_in);
        {we_n_out, ce_n_out, reg_n_out} <= 3'h7;
        // Released bus shows the inverse so stale data never looks valid
        cfg_data_out <= ~d;
    endtask
    task automatic ack(input int dly);
        repeat (dly) @(posedge clk_in);
        ack_out <= 1'b1;
        @(posedge clk_in);
        ack_out <= 1'b0;
    endtask
endmodule // pcir_host_model

// File: tb/pcir_ctrl_tb_top.sv
// Self-checking bench for the card ready/busy and interrupt controller
`timescale 1ns/10ps
`include "pcir_consts.vh"
bind pcir_ctrl pcir_chk #(.PULSE_CYCLES(PULSE_CYCLES)) pcir_chk_i (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .card_iface_reset_in(card_iface_reset_in),
    .emulator_int_line_in(emulator_int_line_in), .host_write_strobe_n_in(host_write_strobe_n_in),
    .host_card_enable_n_in(host_card_enable_n_in), .host_cfg_wr_in(host_cfg_wr_in),
    .host_attr_select_n_in(host_attr_select_n_in), .host_cfg_data_in(host_cfg_data_in),
    .host_int_ack_in(host_int_ack_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .card_ready_busy_irq_n_out(card_ready_busy_irq_n_out),
    .card_status_change_out(card_status_change_out), .attr_write_ok_out(attr_write_ok_out));
module pcir_ctrl_tb_top;
    logic clk_in, rst_n_in, card_rst, emu, reg_wr, reg_rd, a, f;
    logic [3:0] addr;
    logic [7:0] wdata;
    wire we_n, ce_n, sel_n, cfg_wr, ack, pin_n, stschg, wr_ok, fw_irq;
    wire [7:0] cfg_data, rdata;
    int fails, checked, n;
    pcir_host_model host_i (.clk_in(clk_in), .attr_ok_in(wr_ok), .we_n_out(we_n),
        .ce_n_out(ce_n), .reg_n_out(sel_n), .cfg_wr_out(cfg_wr), .cfg_data_out(cfg_data),
        .ack_out(ack));
    pcir_ctrl #(.PULSE_CYCLES(10)) pcir_ctrl_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .card_iface_reset_in(card_rst), .emulator_int_line_in(emu),
        .host_write_strobe_n_in(we_n), .host_card_enable_n_in(ce_n),
        .host_attr_select_n_in(sel_n), .host_cfg_wr_in(cfg_wr), .host_cfg_data_in(cfg_data),
        .host_int_ack_in(ack), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .card_ready_busy_irq_n_out(pin_n),
        .card_status_change_out(stschg), .attr_write_ok_out(wr_ok), .fw_irq_out(fw_irq));
    task automatic complete_run();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk_in);
        {reg_wr, addr, wdata} <= {1'b1, ad, d};
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdc(input logic [3:0] ad, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_in);
        {reg_rd, addr} <= {1'b1, ad};
        @(posedge clk_in);
        reg_rd <= 1'b0;
        @(negedge clk_in);
        chk(rdata & m, e);
    endtask
    // Bounded wait for a pin level, n counts the cycles taken
    task automatic wait_pin(input logic lvl);
        for (n = 0; pin_n !== lvl; n++) begin
            if (n == 60) begin
                fails++;
                complete_run();
            end
            @(negedge clk_in);
        end
    endtask
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        {rst_n_in, card_rst, emu, reg_wr, reg_rd, addr, wdata} = 17'h0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(negedge clk_in);
        chk(pin_n, 0);
        host_i.host_write(8'h41, 1'b1, a);
        chk(a, 0);
        rdc(`PCIR_ADDR_OPTION, 8'hff, 8'h00);
        rdc(`PCIR_ADDR_IRQ_STAT, 8'h04, 8'h04);
        // Mask flips the firmware interrupt, clearing empties the status
        wr(`PCIR_ADDR_IRQ_MASK, 8'hff);
        repeat (2) @(negedge clk_in);
        f = fw_irq;
        wr(`PCIR_ADDR_IRQ_MASK, 8'h00);
        repeat (2) @(negedge clk_in);
        chk(f, 1);
        chk(fw_irq, 0);
        wr(`PCIR_ADDR_IRQ_STAT, 8'h07);
        repeat (2) @(negedge clk_in);
        chk(fw_irq, 0);
        rdc(`PCIR_ADDR_IRQ_STAT, 8'h07, 8'h00);
        wr(`PCIR_ADDR_CTRL, 8'h03);
        repeat (2) @(negedge clk_in);
        chk(pin_n, 1);
        chk(stschg, 1);
        wr(`PCIR_ADDR_CTRL, 8'h01);
        repeat (2) @(negedge clk_in);
        chk(stschg, 0);
        host_i.host_write(8'h41, 1'b1, a);
        chk(a, 1);
        rdc(`PCIR_ADDR_OPTION, 8'hff, 8'h41);
        @(posedge clk_in);
        emu <= 1'b1;
        wait_pin(0);
        wait_pin(1);
        chk(8'(n >= 10), 1);
        @(posedge clk_in);
        emu <= 1'b0;
        host_i.host_write(8'h01, 1'b1, a);
        emu <= 1'b1;
        wait_pin(0);
        @(posedge clk_in);
        emu <= 1'b0;
        repeat (20) @(negedge clk_in);
        chk(pin_n, 0);
        host_i.ack(3);
        wait_pin(1);
        chk(8'(n < 5), 1);
        @(posedge clk_in);
        card_rst <= 1'b1;
        @(posedge clk_in);
        card_rst <= 1'b0;
        repeat (2) @(negedge clk_in);
        chk(pin_n, 0);
        rdc(`PCIR_ADDR_OPTION, 8'hff, 8'h00);
        rdc(`PCIR_ADDR_CTRL, 8'h05, 8'h00);
        rdc(`PCIR_ADDR_IRQ_STAT, 8'h01, 8'h01);
        host_i.host_write(8'h41, 1'b1, a);
        chk(a, 0);
        rdc(4'hf, 8'hff, 8'h00);
        complete_run();
    end
endmodule // pcir_ctrl_tb_top
